// File: dv/sost_far_model.sv
// Far side: shutter and substrate timing sources plus done pulses.
// Assumes starts are one-cycle pclk pulses; LAT sets generator delay.
`timescale 1ns/100ps
`default_nettype none
module sost_far_model #(parameter int LAT = 10) (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  exposure_start,
  input wire logic  readout_start,
  output logic [3:0] shutter_gen,
  output logic      substrate_mux_a,
  output logic      substrate_mux_b,
  output logic      shutter_pair_mux,
  output logic      exposure_done,
  output logic      readout_done
);
  logic [6:0] cnt;   // Source pattern counter
  logic [7:0] e_cnt; // Exposure cycles left
  logic [7:0] r_cnt; // Readout cycles left
  // Scrambled so every source differs from its neighbours often
  assign {shutter_pair_mux, substrate_mux_b, substrate_mux_a, shutter_gen} =
    cnt ^ {cnt[2:0], cnt[6:3]};
  // Sources run all the time; done fires LAT+1 cycles after a start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 7'h00;
      e_cnt <= 8'h00;
      r_cnt <= 8'h00;
      exposure_done <= 1'b0;
      readout_done <= 1'b0;
    end else begin
      cnt <= cnt + 7'h01;
      if (exposure_start) e_cnt <= 8'(LAT);
      else if (e_cnt != 8'h00) e_cnt <= e_cnt - 8'h01;
      if (readout_start) r_cnt <= 8'(LAT);
      else if (r_cnt != 8'h00) r_cnt <= r_cnt - 8'h01;
      exposure_done <= (e_cnt == 8'h01);
      readout_done <= (r_cnt == 8'h01);
    end
  end
endmodule // sost_far_model
`default_nettype wire

// File: dv/sost_top_bench.sv
// Self-checking bench: APB register tests of routing and triggers.
// Assumes sost_top, its register header and the far-side model.
`timescale 1ns/100ps
`default_nettype none
`include "sost_regs.vh"
module sost_top_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        vertical_sync = 0;      // Field boundary pin
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, sa, sb, pr, ed, rd_d;
  logic [3:0]  sg, ss;                 // Sources, shutter starts
  logic        sub, mech, strb, tst, s_a, s_b, es, rs;
  int          n_fail = 0, checks = 0, t_e, t_r;
  logic [2:0]  codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7}; // No 6
  always #20 pclk = ~pclk;
  sost_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .vertical_sync, .shutter_gen(sg), .substrate_mux_a(sa),
    .substrate_mux_b(sb), .shutter_pair_mux(pr), .exposure_done(ed), .readout_done(rd_d),
    .substrate_clear_pin(sub), .mech_shutter_pin(mech), .flash_strobe_pin(strb),
    .test_out_pin(tst), .shutter_start(ss), .substrate_a_start(s_a),
    .substrate_b_start(s_b), .exposure_start(es), .readout_start(rs));
  sost_far_model #(.LAT(10)) far (.pclk, .presetn, .exposure_start(es),
    .readout_start(rs), .shutter_gen(sg), .substrate_mux_a(sa), .substrate_mux_b(sb),
    .shutter_pair_mux(pr), .exposure_done(ed), .readout_done(rd_d));
  task automatic results;
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // 33 bits so a response flag packed above a data word is compared too
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No assumed latency; only the watchdog ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, 0);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 0, q, e);
    chk({e, q}, {1'b0, x});
  endtask
  // Pulse the sync pin and collect every start pulse of the field
  task automatic boundary(output logic [7:0] g, output int nh);
    logic [7:0] v;
    g = 0;
    nh = 0;
    t_e = 0;
    t_r = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      vertical_sync <= (i < 6);
      @(negedge pclk);
      v = {rs, es, s_b, s_a, ss};
      g |= v;
      nh += $countones(v);
      if (es) t_e = i;
      if (rs) t_r = i;
    end
  endtask
  function automatic logic src(input logic [2:0] c, input logic [6:0] s);
    src = (c == `SOST_CODE_PAIR) ? s[6] : s[c];
  endfunction
  // Each pin must show its selected source one edge later
  task automatic check_pins(input logic [11:0] r);
    logic [6:0] s;
    repeat (3) begin
      @(negedge pclk);
      s = {pr, sb, sa, sg};
      @(negedge pclk);
      chk({tst, strb, mech, sub}, {src(r[11:9], s), src(r[8:6], s), src(r[5:3], s),
          src(r[2:0], s)});
    end
  endtask
  initial begin
    #200000;
    n_fail++;
    results;
  end
  initial begin
    logic [31:0] q;
    logic        e;
    logic [7:0]  g;
    logic [11:0] rt, old;
    int          nh;
    repeat (8) @(posedge pclk);
    chk({ss, s_a, s_b, es, rs, sub, mech, strb, tst, pready}, 13'h0001);
    presetn <= 1'b1;
    rd_chk(`SOST_ROUTE_ADDR, 32'h0000_0688);
    rd_chk(`SOST_TRIG_ADDR, 32'h0000_0000);
    apb(1'b0, 12'h008, 0, q, e);
    chk({e, q}, 33'h1_0000_0000);
    apb(1'b1, `SOST_STATUS_ADDR, 32'hFFFF_FFFF, q, e);
    chk(e, 1);
    old = 12'h688;
    check_pins(old);
    // Every legal code on every pin, applied only at the boundary
    for (int i = 0; i < 7; i++) begin
      rt = {codes[(i + 3) % 7], codes[(i + 2) % 7], codes[(i + 1) % 7], codes[i]};
      wr(`SOST_ROUTE_ADDR, rt);
      rd_chk(`SOST_ROUTE_ADDR, rt);
      rd_chk(`SOST_STATUS_ADDR, {16'h0000, 4'h4, old});
      check_pins(old);
      boundary(g, nh);
      chk(nh, 0);
      check_pins(rt);
      old = rt;
    end
    rd_chk(`SOST_STATUS_ADDR, {20'h00000, old});
    // Single generator bits, then all of them at once
    for (int b = 0; b < 7; b++) begin
      q = (b < 6) ? (32'h1 << b) : 32'h3F;
      wr(`SOST_TRIG_ADDR, q);
      rd_chk(`SOST_TRIG_ADDR, q);
      boundary(g, nh);
      chk(g, q);
      chk(nh, $countones(q));
      rd_chk(`SOST_TRIG_ADDR, 0);
    end
    wr(`SOST_TRIG_ADDR, 32'hC0);
    boundary(g, nh);
    chk({g, 8'(nh)}, 16'hC002);
    // Far model ends exposure 11 cycles on; readout follows the done pulse
    chk(t_r, t_e + 12);
    wr(`SOST_TRIG_ADDR, 32'h80);
    boundary(g, nh);
    chk(g, 32'h80);
    rd_chk(`SOST_STATUS_ADDR, {8'h00, 8'h80, 4'h0, old});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`SOST_ROUTE_ADDR, 32'h0000_0688);
    check_pins(12'h688);
    results;
  end
endmodule // sost_top_bench
`default_nettype wire

// File: dv/sost_top_monitor.sv
// Checker for the shutter output select block, bound to sost_top.
// Assumes one pclk domain and sees only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "sost_regs.vh"
module sost_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        vertical_sync,
  input wire logic [3:0]  shutter_gen,
  input wire logic        exposure_done,
  input wire logic        substrate_clear_pin,
  input wire logic        mech_shutter_pin,
  input wire logic        flash_strobe_pin,
  input wire logic        test_out_pin,
  input wire logic [3:0]  shutter_start,
  input wire logic        substrate_a_start,
  input wire logic        substrate_b_start,
  input wire logic        exposure_start,
  input wire logic        readout_start
);
  logic       vs_q;    // Last sampled sync pin
  logic [7:0] vs_age;  // Cycles since pin rise, saturating
  logic [1:0] up;      // Cycles since reset release
  logic       rt_wr;   // Routing written since reset
  logic       exp_run; // Exposure in flight
  logic       acc;     // APB access cycle
  logic       gen_go;  // Any generator start
  logic       mapped;  // Trigger or routing address
  assign acc = psel & penable;
  assign gen_go = (|shutter_start) | substrate_a_start | substrate_b_start;
  assign mapped = (paddr == `SOST_TRIG_ADDR) | (paddr == `SOST_ROUTE_ADDR);
  // Helpers; age starts saturated so no start is legal before a field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_q <= 1'b0;
      vs_age <= 8'hFF;
      up <= 2'h0;
      rt_wr <= 1'b0;
      exp_run <= 1'b0;
    end else begin
      vs_q <= vertical_sync;
      if (vertical_sync & ~vs_q) vs_age <= 8'h00;
      else if (vs_age != 8'hFF) vs_age <= vs_age + 8'h01;
      if (up != 2'h3) up <= up + 2'h1;
      if (acc & pwrite & (paddr == `SOST_ROUTE_ADDR)) rt_wr <= 1'b1;
      if (exposure_start) exp_run <= 1'b1;
      else if (exposure_done) exp_run <= 1'b0;
    end
  end
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sub_default_a: assert property (!rt_wr && up == 2'h3 |->
    substrate_clear_pin == $past(shutter_gen[0])) else $error("substrate pin source");
  mech_default_a: assert property (!rt_wr && up == 2'h3 |->
    mech_shutter_pin == $past(shutter_gen[1])) else $error("shutter pin source");
  strobe_default_a: assert property (!rt_wr && up == 2'h3 |->
    flash_strobe_pin == $past(shutter_gen[2])) else $error("strobe pin source");
  test_default_a: assert property (!rt_wr && up == 2'h3 |->
    test_out_pin == $past(shutter_gen[3])) else $error("test pin source");
  start_window_a: assert property (gen_go |-> vs_age >= 8'h02 && vs_age <= 8'h0A)
    else $error("start outside field boundary");
  start_pulse_a: assert property (gen_go |=> !gen_go)
    else $error("start pulse too long");
  exp_window_a: assert property (exposure_start |-> vs_age >= 8'h02 && vs_age <= 8'h0C)
    else $error("exposure start late");
  read_after_a: assert property (exp_run |-> !readout_start)
    else $error("readout during exposure");
  unmapped_a: assert property (acc && !mapped && paddr != `SOST_STATUS_ADDR |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
endmodule // sost_top_monitor
bind sost_top sost_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pslverr, .vertical_sync, .shutter_gen, .exposure_done, .substrate_clear_pin,
  .mech_shutter_pin, .flash_strobe_pin, .test_out_pin, .shutter_start,
  .substrate_a_start, .substrate_b_start, .exposure_start, .readout_start);
`default_nettype wire

// File: rtl/sost_out_mux.v
// One output pin selector: a 3-bit code picks a timing source.
// Assumes all sources are on pclk; the pin is driven from a flop.
`timescale 1ns/100ps
`default_nettype none
`include "sost_regs.vh"

module sost_out_mux (
  input  wire        pclk,          // Pixel clock
  input  wire        presetn,       // Async reset, active low
  input  wire [2:0]  sel,           // Active select code
  input  wire [3:0]  shutter_gen,   // Shutter generators 0..3
  input  wire        substrate_mux_a, // Substrate mux A output
  input  wire        substrate_mux_b, // Substrate mux B output
  input  wire        shutter_pair_mux, // Shutter pair mux output
  output reg         pin            // Registered output pin
);

  // Decode of one select code; code 6 drives low as a safe level
  function pick;
    input [2:0] code;
    input [3:0] gen;
    input       sa;
    input       sb;
    input       pr;
    begin
      if (code[2] == 1'b0) begin
        pick = gen[code[1:0]];                  // see RQ2
      end else if (code == `SOST_CODE_SUB_A) begin
        pick = sa;                              // see RQ3
      end else if (code == `SOST_CODE_SUB_B) begin
        pick = sb;                              // see RQ3
      end else if (code == `SOST_CODE_PAIR) begin
        pick = pr;                              // see RQ3
      end else begin
        pick = 1'b0;
      end
    end
  endfunction

  // Register the pin so it never glitches while the code settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
    end else begin
      pin <= pick(sel, shutter_gen, substrate_mux_a, substrate_mux_b, shutter_pair_mux);
    end
  end

endmodule // sost_out_mux
`default_nettype wire

// File: rtl/sost_regs.vh
// Register map, field layout, reset values and state codes of the
// shutter output select and trigger block.
// Assumes a 32-bit APB slave; each register index maps to byte index*4.
//
// Functional notes
// (RQ1) Bits 2:0 pick the substrate clear source
// (RQ2) Codes 0..3 route shutter generators 0..3
// (RQ3) Codes 4,5,7 route muxes; 6 forbidden
// (RQ4) Bits 5:3 pick mechanical shutter, reset 1
// (RQ5) Bits 8:6 pick flash strobe, reset 2
// (RQ6) Bits 11:9 pick test output, reset 3
// (RQ7) Eight trigger bits; ones start operations
// (RQ8) Bits 0..5 start shutter and substrate generators
// (RQ9) Bit6 exposure, bit7 readout, readout follows exposure
// (RQ10) New values apply at next vertical sync
`ifndef SOST_REGS_VH
`define SOST_REGS_VH

// Register indices and their byte addresses
`define SOST_TRIG_IDX        12'h001
`define SOST_ROUTE_IDX       12'h050
`define SOST_STATUS_IDX      12'h05F
`define SOST_TRIG_ADDR       12'h004
`define SOST_ROUTE_ADDR      12'h140
`define SOST_STATUS_ADDR     12'h17C

// Widths of the two documented registers and of one select field
`define SOST_TRIG_W          8
`define SOST_ROUTE_W         12
`define SOST_SEL_W           3

// Select field positions (low bit of each field)
`define SOST_SUB_SEL_LSB     0
`define SOST_MECH_SEL_LSB    3
`define SOST_STRB_SEL_LSB    6
`define SOST_TEST_SEL_LSB    9

// Reset values
`define SOST_SUB_SEL_RST     3'h0
`define SOST_MECH_SEL_RST    3'h1
`define SOST_STRB_SEL_RST    3'h2
`define SOST_TEST_SEL_RST    3'h3
`define SOST_TRIG_RST        8'h00
`define SOST_ROUTE_RST       12'h688

// Select codes for the non-generator sources and the forbidden code 6
`define SOST_CODE_SUB_A      3'h4
`define SOST_CODE_SUB_B      3'h5
`define SOST_CODE_BAD        3'h6
`define SOST_CODE_PAIR       3'h7

// Trigger bit positions
`define SOST_TRIG_SUB_A      4
`define SOST_TRIG_SUB_B      5
`define SOST_TRIG_EXPOSE     6
`define SOST_TRIG_READOUT    7

// Status register field positions
`define SOST_ST_EXP_BUSY     12
`define SOST_ST_RD_BUSY      13
`define SOST_ST_ROUTE_PEND   14
`define SOST_ST_TRIG_PEND    15
`define SOST_ST_LAST_TRIG    16

// Sequencer one-hot states
`define SOST_SEQ_IDLE        3'h1
`define SOST_SEQ_EXPOSE      3'h2
`define SOST_SEQ_READ        3'h4

`endif

// File: rtl/sost_seq.v
// Exposure and readout sequencer started by trigger bits 6 and 7.
// Assumes done inputs are one-cycle pulses from generators on pclk.
`timescale 1ns/100ps
`default_nettype none
`include "sost_regs.vh"

module sost_seq (
  input  wire        pclk,           // Pixel clock
  input  wire        presetn,        // Async reset, active low
  input  wire        go_exposure,    // Start exposure, one-cycle pulse
  input  wire        go_readout,     // Start readout, one-cycle pulse
  input  wire        exposure_done,  // Exposure generator finished
  input  wire        readout_done,   // Readout generator finished
  output reg         exposure_start, // Pulse to exposure logic
  output reg         readout_start,  // Pulse to readout logic
  output wire        exposure_busy,  // Exposure in progress
  output wire        readout_busy    // Readout in progress
);

  localparam [2:0] ST_IDLE   = `SOST_SEQ_IDLE;
  localparam [2:0] ST_EXPOSE = `SOST_SEQ_EXPOSE;
  localparam [2:0] ST_READ   = `SOST_SEQ_READ;

  reg [2:0] state;        // One-hot state
  reg       read_queued;  // Readout waits for exposure end

  assign exposure_busy = state[1];
  assign readout_busy  = state[2];

  // Triggers arriving while busy are dropped; software must wait for idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= ST_IDLE;
      read_queued    <= 1'b0;
      exposure_start <= 1'b0;
      readout_start  <= 1'b0;
    end else begin
      exposure_start <= 1'b0;
      readout_start  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go_exposure) begin
            exposure_start <= 1'b1;                 // see RQ9
            read_queued    <= go_readout;           // see RQ9
            state          <= ST_EXPOSE;
          end else if (go_readout) begin
            readout_start <= 1'b1;                  // see RQ9
            state         <= ST_READ;
          end
        end
        ST_EXPOSE: begin
          if (exposure_done) begin
            read_queued <= 1'b0;
            if (read_queued) begin
              readout_start <= 1'b1;                // see RQ9
              state         <= ST_READ;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          if (readout_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sost_seq
`default_nettype wire

// File: rtl/sost_top.v
// Shutter output select and trigger block: APB registers, vertical
// sync shadowing, four routed output pins and generator start pulses.
// Assumes generator and mux inputs are on pclk; vertical_sync is a pin.
`timescale 1ns/100ps
`default_nettype none
`include "sost_regs.vh"

module sost_top (
  input  wire        pclk,              // Pixel clock, 25 MHz
  input  wire        presetn,           // Async reset, active low
  // APB slave
  input  wire        psel,              // Slave select
  input  wire        penable,           // Access phase
  input  wire        pwrite,            // Write when high
  input  wire [11:0] paddr,             // Byte address
  input  wire [31:0] pwdata,            // Write data
  output wire        pready,            // Always ready
  output reg  [31:0] prdata,            // Read data, from flops
  output wire        pslverr,           // Unmapped address or status write
  // Field boundary pin
  input  wire        vertical_sync,     // Asynchronous pin
  // Internal timing sources
  input  wire [3:0]  shutter_gen,       // Shutter generators 0..3
  input  wire        substrate_mux_a,   // Substrate mux A output
  input  wire        substrate_mux_b,   // Substrate mux B output
  input  wire        shutter_pair_mux,  // Shutter pair mux output
  input  wire        exposure_done,     // Exposure finished pulse
  input  wire        readout_done,      // Readout finished pulse
  // Routed pins
  output wire        substrate_clear_pin, // Substrate clear
  output wire        mech_shutter_pin,  // Mechanical shutter
  output wire        flash_strobe_pin,  // Flash strobe
  output wire        test_out_pin,      // Test output
  // Generator starts, one-cycle pulses
  output reg  [3:0]  shutter_start,     // Start shutter generators
  output reg         substrate_a_start, // Start substrate generator A
  output reg         substrate_b_start, // Start substrate generator B
  output wire        exposure_start,    // Start exposure sequence
  output wire        readout_start      // Start readout sequence
);

  localparam NPIN = 4;                  // Routed pins

  // Shadow copies written by software
  reg [`SOST_ROUTE_W-1:0] route_shadow;   // Pending routing
  reg [`SOST_TRIG_W-1:0]  trig_shadow;    // Pending trigger bits
  reg                     route_pend;     // Routing write not yet applied
  // Active copies used by the hardware
  reg [`SOST_ROUTE_W-1:0] route_active;   // Routing driving the muxes
  reg [`SOST_TRIG_W-1:0]  trig_last;      // Last trigger applied

  // Vertical sync synchroniser and edge detector
  reg vs_meta;                          // First stage, read by vs_sync only
  reg vs_sync;                          // Second stage
  reg vs_prev;                          // Delayed for edge detect
  wire field_edge;                      // Start of a new field

  // APB decode
  wire setup_phase;                     // Setup cycle of a transfer
  wire access_phase;                    // Completing cycle
  wire wr_now;                          // Write takes effect
  wire hit_trig;                        // Trigger address
  wire hit_route;                       // Routing address
  wire hit_status;                      // Status address
  wire hit_any;                         // Any mapped address

  // Sequencer
  reg  go_exposure;                     // Exposure bit applied
  reg  go_readout;                      // Readout bit applied
  wire exposure_busy;                   // Sequencer exposing
  wire readout_busy;                    // Sequencer reading out

  // Status word assembled from live state
  wire [31:0] status_word;

  // Decode of an address against a byte address constant
  function is_addr;
    input [11:0] a;
    input [11:0] target;
    begin
      is_addr = (a == target);
    end
  endfunction

  // Two flops before the pin is looked at; the edge uses stage two only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_meta <= 1'b0;
      vs_sync <= 1'b0;
      vs_prev <= 1'b0;
    end else begin
      vs_meta <= vertical_sync;
      vs_sync <= vs_meta;
      vs_prev <= vs_sync;
    end
  end

  // Rising edge of the synchronised sync marks the field boundary
  assign field_edge = vs_sync & ~vs_prev;

  // Zero wait states: every access finishes in its first access cycle
  assign pready       = 1'b1;
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_now       = access_phase & pwrite;

  // Indices are word indices; the bus sees them times four
  assign hit_trig   = is_addr(paddr, `SOST_TRIG_ADDR);
  assign hit_route  = is_addr(paddr, `SOST_ROUTE_ADDR);
  assign hit_status = is_addr(paddr, `SOST_STATUS_ADDR);
  assign hit_any    = hit_trig | hit_route | hit_status;

  // Unmapped addresses error; writes to status are also refused
  assign pslverr = access_phase & (~hit_any | (pwrite & hit_status));

  // Routing shadow; the pending flag lets software see an unapplied write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_shadow <= `SOST_ROUTE_RST;
      route_pend   <= 1'b0;
    end else begin
      if (wr_now && hit_route) begin
        route_shadow <= pwdata[`SOST_ROUTE_W-1:0];   // see RQ10
        route_pend   <= 1'b1;
      end else if (field_edge) begin
        route_pend <= 1'b0;
      end
    end
  end

  // Trigger shadow; a write in the boundary cycle survives to the next
  // boundary rather than being cleared, so no request is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_shadow <= `SOST_TRIG_RST;
    end else begin
      if (wr_now && hit_trig) begin
        trig_shadow <= pwdata[`SOST_TRIG_W-1:0];     // see RQ7
      end else if (field_edge) begin
        trig_shadow <= `SOST_TRIG_RST;               // see RQ10
      end
    end
  end

  // Active routing and trigger snapshot change only at the boundary
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_active <= `SOST_ROUTE_RST;               // see RQ1
      trig_last    <= `SOST_TRIG_RST;
    end else begin
      if (field_edge) begin
        route_active <= route_shadow;                // see RQ10
        trig_last    <= trig_shadow;
      end
    end
  end

  // Start pulses, one cycle wide, for each trigger bit set high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutter_start     <= 4'h0;
      substrate_a_start <= 1'b0;
      substrate_b_start <= 1'b0;
      go_exposure       <= 1'b0;
      go_readout        <= 1'b0;
    end else begin
      if (field_edge) begin
        shutter_start     <= trig_shadow[3:0];                     // see RQ8
        substrate_a_start <= trig_shadow[`SOST_TRIG_SUB_A];        // see RQ8
        substrate_b_start <= trig_shadow[`SOST_TRIG_SUB_B];        // see RQ8
        go_exposure       <= trig_shadow[`SOST_TRIG_EXPOSE];       // see RQ9
        go_readout        <= trig_shadow[`SOST_TRIG_READOUT];      // see RQ9
      end else begin
        shutter_start     <= 4'h0;
        substrate_a_start <= 1'b0;
        substrate_b_start <= 1'b0;
        go_exposure       <= 1'b0;
        go_readout        <= 1'b0;
      end
    end
  end

  // Exposure then readout ordering lives in its own small machine
  sost_seq u_seq (
    .pclk           (pclk),
    .presetn        (presetn),
    .go_exposure    (go_exposure),
    .go_readout     (go_readout),
    .exposure_done  (exposure_done),
    .readout_done   (readout_done),
    .exposure_start (exposure_start),
    .readout_start  (readout_start),
    .exposure_busy  (exposure_busy),
    .readout_busy   (readout_busy)
  );

  // Four identical selectors, one per pin, each on its own 3-bit field
  wire [NPIN-1:0] pin_out;              // Selector outputs in field order

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      sost_out_mux u_mux (
        .pclk             (pclk),
        .presetn          (presetn),
        .sel              (route_active[gi*`SOST_SEL_W +: `SOST_SEL_W]), // see RQ4
        .shutter_gen      (shutter_gen),
        .substrate_mux_a  (substrate_mux_a),
        .substrate_mux_b  (substrate_mux_b),
        .shutter_pair_mux (shutter_pair_mux),
        .pin              (pin_out[gi])
      );
    end
  endgenerate

  // Field order: substrate, mechanical shutter, strobe, test
  assign substrate_clear_pin = pin_out[0];   // see RQ1
  assign mech_shutter_pin    = pin_out[1];   // see RQ4
  assign flash_strobe_pin    = pin_out[2];   // see RQ5
  assign test_out_pin        = pin_out[3];   // see RQ6

  // Status shows the routing the hardware really uses, not the shadow
  assign status_word = {8'h00,
                        trig_last,
                        (|trig_shadow),
                        route_pend,
                        readout_busy,
                        exposure_busy,
                        route_active};

  // Read data is captured in the setup cycle so it comes from a flop;
  // the value therefore reflects state one cycle before completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      if (setup_phase && !pwrite) begin
        if (hit_trig) begin
          prdata <= {24'h000000, trig_shadow};
        end else if (hit_route) begin
          prdata <= {20'h00000, route_shadow};
        end else if (hit_status) begin
          prdata <= status_word;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Code 6 is never to be written (see RQ3); the selector drives low if it is

endmodule // sost_top
`default_nettype wire
